// ===== scd_clock_ctrl.v
`timescale 1ns/1ns
`include "scd_regs.vh"

// Overview of operation
// [RL1] Sample clock divides by one, two or four per the ratio register.
// [RL2] Host writes the divider ratio before applying a multiple-rate clock.
// [RL3] Valid system reference pulse loads the divider with a programmed state.
// [RL4] Per-channel half input period delay, leaving the serial link untouched.
// [RL5] Three-bit select picks fine or fine plus superfine; superfine on 0x2/0x6.
// [RL6] Fine delay offers a 16-step or a 192-step range.
// [RL7] Per-channel eight-bit fine value sets one of 192 steps.
// [RL8] Per-channel eight-bit superfine value gives up to 128 small increments.
// [RL9] Delay changes act at once on the write, no commit step.
// [RL10] Turning fine delay on resets the sample datapath.
// [RL11] Fine and superfine value writes never disturb the serial link.
// [RL12] Host keeps digital delay settings equal to the analog ones.
// [RL13] Two duty stabiliser stages enabled after reset, each with its register.
// [RL14] Power control pin is active high; default function is power-down.
// [RL15] Power-down also set by registers and stops the serial link.
// [RL16] Standby keeps link running, sends zero samples or K characters.
// [RL17] Diode export 0x01 routes small diode, 0x02 the large one.
// [RL18] Host selects both channels and clears other exports before diode export.
// [RL19] Divider load state comes from a held, host-written field.
module scd_clock_ctrl (
    input wire sys_clk,
    input wire rst,
    input wire spiClk,
    input wire spiCsN,
    input wire sdioIn,
    input wire system_reference_input,
    input wire power_control_pin,
    output wire sdioOut,
    output wire sdioOe,
    output reg [1:0] sampleTick,
    output reg [7:0] fineStepA,
    output reg [7:0] fineStepB,
    output reg [7:0] superStepA,
    output reg [7:0] superStepB,
    output reg datapathReset,
    output reg duty_stabiliser_stage_one,
    output reg duty_stabiliser_stage_two,
    output reg powerDown,
    output reg standby,
    output reg linkEnable,
    output reg sampleZero,
    output reg sendKChars,
    output reg diodeSmallExport,
    output reg diodeLargeExport,
    output reg refExternalEn,
    output reg common_mode_voltage_export
);
    wire [14:0] regAddr;
    wire [7:0] wrData;
    wire wrStb;
    reg [7:0] rdData;

    reg [7:0] channelSelect;
    reg [7:0] powerControlA;
    reg [7:0] powerControlB;
    reg [7:0] dividerRatio;
    reg [7:0] halfPeriodDelay;
    reg [7:0] refSyncCtrl;
    reg [7:0] delaySel [0:1];
    reg [7:0] superVal [0:1];
    reg [7:0] fineVal [0:1];
    reg [7:0] dutyCtrlA;
    reg [7:0] dutyCtrlB;
    reg [7:0] standbyOutSel;
    reg [7:0] refExportCtrl;
    reg [7:0] cmExportCtrl;
    reg [7:0] diodeExportSel;

    reg [2:0] refSync;
    reg [2:0] pinSync;
    reg refLvl;
    reg pinLvl;
    reg [1:0] divCnt;
    reg tickRaw;
    reg tickLate;
    reg [3:0] dpRstCnt;
    integer ch;
    wire rdIdx;
    wire refRise;
    wire [1:0] divTop;
    wire [31:0] dpRstLoad;
    wire pdNow;
    wire sbNow;

    scd_spi_port uSpi (
        .sys_clk(sys_clk),
        .rst(rst),
        .spiClk(spiClk),
        .spiCsN(spiCsN),
        .sdioIn(sdioIn),
        .rdData(rdData),
        .regAddr(regAddr),
        .wrData(wrData),
        .wrStb(wrStb),
        .sdioOut(sdioOut),
        .sdioOe(sdioOe)
    );

    // Terminal count of the divider for a ratio code
    function [1:0] div_top;
        input [1:0] code;
        begin
            if (code == `SCD_DIV_BY4)
                div_top = 2'h3;
            else if (code == `SCD_DIV_BY2)
                div_top = 2'h1;
            else
                div_top = 2'h0;
        end
    endfunction

    // Fine step from select and value: 16-step or 192-step range
    function [7:0] fine_step;
        input [2:0] sel;
        input [7:0] val;
        begin
            if (sel == `SCD_DLY_OFF)
                fine_step = 8'h00;
            else if (sel == `SCD_DLY_FINE16)
                fine_step = {4'h0, val[3:0]};
            else if (val > `SCD_FINE_MAX)
                fine_step = `SCD_FINE_MAX;
            else
                fine_step = val;
        end
    endfunction

    // Superfine step, active only for the two superfine select codes
    function [7:0] super_step;
        input [2:0] sel;
        input [7:0] val;
        begin
            if (sel != `SCD_DLY_SUPER_A && sel != `SCD_DLY_SUPER_B)
                super_step = 8'h00;
            else if (val > `SCD_SUPER_MAX)
                super_step = `SCD_SUPER_MAX;
            else
                super_step = val;
        end
    endfunction

    // Per-channel reads show channel A whenever A is selected, otherwise channel B
    assign rdIdx = ~channelSelect[0];
    assign divTop = div_top(dividerRatio[1:0]);
    assign refRise = (refSync[1] == refSync[2]) & refSync[2] & ~refLvl;

    // Power state shared by all power outputs so they change together
    assign pdNow = (pinLvl && powerControlB[1:0] == `SCD_PIN_POWER_OFF) ||
        powerControlA[`SCD_SWPD_BIT];
    assign sbNow = pinLvl && powerControlB[1:0] == `SCD_PIN_STANDBY &&
        !powerControlA[`SCD_SWPD_BIT];
    assign dpRstLoad = `SCD_DP_RST_CYC;

    // Read-back mux
    always @* begin
        rdData = 8'h00;
        if (regAddr == `SCD_ADDR_CHAN_SEL)
            rdData = channelSelect;
        else if (regAddr == `SCD_ADDR_PWR_A)
            rdData = powerControlA;
        else if (regAddr == `SCD_ADDR_PWR_B)
            rdData = powerControlB;
        else if (regAddr == `SCD_ADDR_DIV_RATIO)
            rdData = dividerRatio;
        else if (regAddr == `SCD_ADDR_HALF_DELAY)
            rdData = halfPeriodDelay;
        else if (regAddr == `SCD_ADDR_REF_SYNC)
            rdData = refSyncCtrl;
        else if (regAddr == `SCD_ADDR_DELAY_SEL)
            rdData = delaySel[rdIdx];
        else if (regAddr == `SCD_ADDR_SUPERFINE)
            rdData = superVal[rdIdx];
        else if (regAddr == `SCD_ADDR_FINE)
            rdData = fineVal[rdIdx];
        else if (regAddr == `SCD_ADDR_DUTY_A)
            rdData = dutyCtrlA;
        else if (regAddr == `SCD_ADDR_DUTY_B)
            rdData = dutyCtrlB;
        else if (regAddr == `SCD_ADDR_STANDBY_OUT)
            rdData = standbyOutSel;
        else if (regAddr == `SCD_ADDR_REF_EXPORT)
            rdData = refExportCtrl;
        else if (regAddr == `SCD_ADDR_CM_EXPORT)
            rdData = cmExportCtrl;
        else if (regAddr == `SCD_ADDR_DIODE_EXPORT)
            rdData = diodeExportSel;
    end

    // Register writes; per-channel registers go to every selected channel
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            channelSelect <= `SCD_RST_CHAN_SEL;
            powerControlA <= `SCD_RST_ZERO;
            powerControlB <= `SCD_RST_ZERO;
            dividerRatio <= `SCD_RST_ZERO;
            halfPeriodDelay <= `SCD_RST_ZERO;
            refSyncCtrl <= `SCD_RST_ZERO;
            // [RL13] stabiliser on after reset
            dutyCtrlA <= `SCD_RST_DUTY;
            dutyCtrlB <= `SCD_RST_DUTY;
            standbyOutSel <= `SCD_RST_ZERO;
            refExportCtrl <= `SCD_RST_ZERO;
            cmExportCtrl <= `SCD_RST_ZERO;
            diodeExportSel <= `SCD_RST_ZERO;
            for (ch = 0; ch < 2; ch = ch + 1) begin
                delaySel[ch] <= `SCD_RST_ZERO;
                superVal[ch] <= `SCD_RST_ZERO;
                fineVal[ch] <= `SCD_RST_ZERO;
            end
        end else if (wrStb) begin
            if (regAddr == `SCD_ADDR_CHAN_SEL)
                channelSelect <= wrData;
            else if (regAddr == `SCD_ADDR_PWR_A)
                powerControlA <= wrData;
            else if (regAddr == `SCD_ADDR_PWR_B)
                powerControlB <= wrData;
            else if (regAddr == `SCD_ADDR_DIV_RATIO)
                dividerRatio <= wrData;
            else if (regAddr == `SCD_ADDR_HALF_DELAY)
                halfPeriodDelay <= wrData;
            // [RL19] held load state
            else if (regAddr == `SCD_ADDR_REF_SYNC)
                refSyncCtrl <= wrData;
            else if (regAddr == `SCD_ADDR_DUTY_A)
                dutyCtrlA <= wrData;
            else if (regAddr == `SCD_ADDR_DUTY_B)
                dutyCtrlB <= wrData;
            else if (regAddr == `SCD_ADDR_STANDBY_OUT)
                standbyOutSel <= wrData;
            else if (regAddr == `SCD_ADDR_REF_EXPORT)
                refExportCtrl <= wrData;
            else if (regAddr == `SCD_ADDR_CM_EXPORT)
                cmExportCtrl <= wrData;
            else if (regAddr == `SCD_ADDR_DIODE_EXPORT)
                diodeExportSel <= wrData;
            for (ch = 0; ch < 2; ch = ch + 1) begin
                if (channelSelect[ch]) begin
                    if (regAddr == `SCD_ADDR_DELAY_SEL)
                        delaySel[ch] <= wrData;
                    else if (regAddr == `SCD_ADDR_SUPERFINE)
                        superVal[ch] <= wrData;
                    else if (regAddr == `SCD_ADDR_FINE)
                        fineVal[ch] <= wrData;
                end
            end
        end
    end

    // Pin synchronisers with stage two/three agreement
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            refSync <= 3'h0;
            pinSync <= 3'h0;
            refLvl <= 1'b0;
            pinLvl <= 1'b0;
        end else begin
            refSync <= {refSync[1:0], system_reference_input};
            pinSync <= {pinSync[1:0], power_control_pin};
            if (refSync[1] == refSync[2])
                refLvl <= refSync[2];
            if (pinSync[1] == pinSync[2])
                pinLvl <= pinSync[2];
        end
    end

    // Sample divider, resynchronised by the reference pulse
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            divCnt <= 2'h0;
            tickRaw <= 1'b0;
            tickLate <= 1'b0;
            sampleTick <= 2'h0;
        end else begin
            // [RL3] reference pulse loads divider
            if (refRise && refSyncCtrl[`SCD_REF_SYNC_EN_BIT])
                divCnt <= refSyncCtrl[`SCD_REF_SYNC_STATE_LSB +: 2] & divTop;
            // [RL1] divide by 1, 2 or 4
            else if (divCnt >= divTop)
                divCnt <= 2'h0;
            else
                divCnt <= divCnt + 2'h1;
            tickRaw <= (divCnt >= divTop);
            tickLate <= tickRaw;
            // [RL4] half period delay per channel
            sampleTick[0] <= halfPeriodDelay[0] ? tickLate : tickRaw;
            sampleTick[1] <= halfPeriodDelay[1] ? tickLate : tickRaw;
        end
    end

    // Delay outputs follow the registers directly
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fineStepA <= 8'h00;
            fineStepB <= 8'h00;
            superStepA <= 8'h00;
            superStepB <= 8'h00;
        end else begin
            // [RL9] no commit step
            // [RL6] [RL7] fine range
            fineStepA <= fine_step(delaySel[0][2:0], fineVal[0]);
            fineStepB <= fine_step(delaySel[1][2:0], fineVal[1]);
            // [RL5] [RL8] superfine gating
            superStepA <= super_step(delaySel[0][2:0], superVal[0]);
            superStepB <= super_step(delaySel[1][2:0], superVal[1]);
        end
    end

    // Datapath reset pulse when fine delay turns on
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dpRstCnt <= 4'h0;
            datapathReset <= 1'b0;
        end else begin
            // [RL10] enabling fine delay resets datapath
            if (wrStb && regAddr == `SCD_ADDR_DELAY_SEL && wrData[2:0] != `SCD_DLY_OFF &&
                ((channelSelect[0] && delaySel[0][2:0] == `SCD_DLY_OFF) ||
                 (channelSelect[1] && delaySel[1][2:0] == `SCD_DLY_OFF)))
                dpRstCnt <= dpRstLoad[3:0];
            else if (dpRstCnt != 4'h0)
                dpRstCnt <= dpRstCnt - 4'h1;
            // [RL11] value writes leave link alone
            datapathReset <= (dpRstCnt != 4'h0);
        end
    end

    // Power, standby, stabiliser and export controls
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            powerDown <= 1'b0;
            standby <= 1'b0;
            linkEnable <= 1'b0;
            sampleZero <= 1'b0;
            sendKChars <= 1'b0;
            duty_stabiliser_stage_one <= 1'b1;
            duty_stabiliser_stage_two <= 1'b1;
            diodeSmallExport <= 1'b0;
            diodeLargeExport <= 1'b0;
            refExternalEn <= 1'b0;
            common_mode_voltage_export <= 1'b0;
        end else begin
            // [RL14] [RL15] pin high or register bit powers down
            powerDown <= pdNow;
            standby <= sbNow;
            // [RL15] link stops in power-down
            linkEnable <= !pdNow;
            // [RL16] standby fill selection, same cycle as standby
            sampleZero <= sbNow && !standbyOutSel[`SCD_KCHAR_BIT];
            sendKChars <= sbNow && standbyOutSel[`SCD_KCHAR_BIT];
            // [RL13] stabiliser stage enables
            duty_stabiliser_stage_one <= dutyCtrlA[`SCD_DUTY_EN_BIT];
            duty_stabiliser_stage_two <= dutyCtrlB[`SCD_DUTY_EN_BIT];
            // [RL17] diode routing
            diodeSmallExport <= (diodeExportSel == `SCD_DIODE_SMALL);
            diodeLargeExport <= (diodeExportSel == `SCD_DIODE_LARGE);
            refExternalEn <= refExportCtrl[`SCD_REF_EXT_BIT];
            common_mode_voltage_export <= cmExportCtrl[`SCD_CM_EXPORT_BIT];
        end
    end
endmodule // scd_clock_ctrl

// ===== scd_regs.vh
`ifndef SCD_REGS_VH
`define SCD_REGS_VH

// Register offsets on the serial control port
`define SCD_ADDR_CHAN_SEL 15'h0008
`define SCD_ADDR_PWR_A 15'h003F
`define SCD_ADDR_PWR_B 15'h0040
`define SCD_ADDR_DIV_RATIO 15'h0108
`define SCD_ADDR_HALF_DELAY 15'h0109
`define SCD_ADDR_REF_SYNC 15'h010A
`define SCD_ADDR_DELAY_SEL 15'h0110
`define SCD_ADDR_SUPERFINE 15'h0111
`define SCD_ADDR_FINE 15'h0112
`define SCD_ADDR_DUTY_A 15'h011C
`define SCD_ADDR_DUTY_B 15'h011E
`define SCD_ADDR_STANDBY_OUT 15'h0571
`define SCD_ADDR_REF_EXPORT 15'h18A6
`define SCD_ADDR_CM_EXPORT 15'h18E3
`define SCD_ADDR_DIODE_EXPORT 15'h18E6

// Reset values
`define SCD_RST_CHAN_SEL 8'h03
`define SCD_RST_ZERO 8'h00
`define SCD_RST_DUTY 8'h01

// Divider ratio codes, low two bits of the ratio register
`define SCD_DIV_BY1 2'h0
`define SCD_DIV_BY2 2'h1
`define SCD_DIV_BY4 2'h3

// Field positions
`define SCD_REF_SYNC_EN_BIT 0
`define SCD_REF_SYNC_STATE_LSB 1
`define SCD_SWPD_BIT 0
`define SCD_DUTY_EN_BIT 0
`define SCD_KCHAR_BIT 7
`define SCD_REF_EXT_BIT 0
`define SCD_CM_EXPORT_BIT 6

// Delay select codes
`define SCD_DLY_OFF 3'h0
`define SCD_DLY_FINE16 3'h1
`define SCD_DLY_SUPER_A 3'h2
`define SCD_DLY_SUPER_B 3'h6
`define SCD_FINE_MAX 8'hBF
`define SCD_SUPER_MAX 8'h80

// Pin function codes and diode codes
`define SCD_PIN_POWER_OFF 2'h0
`define SCD_PIN_STANDBY 2'h1
`define SCD_DIODE_SMALL 8'h01
`define SCD_DIODE_LARGE 8'h02

// Datapath reset pulse: time in ns and cycles at 8 ns
`define SCD_DP_RST_NS 32
`define SCD_CLK_NS 8
`define SCD_DP_RST_CYC ((`SCD_DP_RST_NS + `SCD_CLK_NS - 1) / `SCD_CLK_NS)

`endif

// ===== scd_spi_port.v
`timescale 1ns/1ns
`include "scd_regs.vh"

module scd_spi_port (
    input wire sys_clk,
    input wire rst,
    input wire spiClk,
    input wire spiCsN,
    input wire sdioIn,
    input wire [7:0] rdData,
    output reg [14:0] regAddr,
    output reg [7:0] wrData,
    output reg wrStb,
    output reg sdioOut,
    output reg sdioOe
);
    reg [2:0] clkSync;
    reg [2:0] csSync;
    reg [2:0] dinSync;
    reg clkLvl;
    reg csLvl;
    reg dinLvl;
    reg [4:0] bitCnt;
    reg [15:0] shiftIn;
    reg [7:0] txShift;
    reg isRead;
    reg loadPend;
    wire clkAgree;
    wire clkRise;
    wire clkFall;

    // Edges count once stages two and three agree
    assign clkAgree = (clkSync[1] == clkSync[2]);
    assign clkRise = clkAgree & clkSync[2] & ~clkLvl;
    assign clkFall = clkAgree & ~clkSync[2] & clkLvl;

    // Three-stage pin synchronisers with agreement filter
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            clkSync <= 3'h0;
            csSync <= 3'h7;
            dinSync <= 3'h0;
            clkLvl <= 1'b0;
            csLvl <= 1'b1;
            dinLvl <= 1'b0;
        end else begin
            clkSync <= {clkSync[1:0], spiClk};
            csSync <= {csSync[1:0], spiCsN};
            dinSync <= {dinSync[1:0], sdioIn};
            if (clkAgree)
                clkLvl <= clkSync[2];
            if (csSync[1] == csSync[2])
                csLvl <= csSync[2];
            if (dinSync[1] == dinSync[2])
                dinLvl <= dinSync[2];
        end
    end

    // 16-bit instruction then 8 data bits, MSB first
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bitCnt <= 5'h00;
            shiftIn <= 16'h0000;
            txShift <= 8'h00;
            isRead <= 1'b0;
            loadPend <= 1'b0;
            regAddr <= 15'h0000;
            wrData <= 8'h00;
            wrStb <= 1'b0;
            sdioOut <= 1'b0;
            sdioOe <= 1'b0;
        end else begin
            wrStb <= 1'b0;
            loadPend <= 1'b0;
            if (loadPend)
                txShift <= rdData;
            if (csLvl) begin
                bitCnt <= 5'h00;
                sdioOe <= 1'b0;
            end else begin
                if (clkRise && bitCnt < 5'h18) begin
                    shiftIn <= {shiftIn[14:0], dinLvl};
                    bitCnt <= bitCnt + 5'h01;
                    if (bitCnt == 5'h0F) begin
                        regAddr <= {shiftIn[13:0], dinLvl};
                        isRead <= shiftIn[14];
                        loadPend <= shiftIn[14];
                    end
                    if (bitCnt == 5'h17 && !isRead) begin
                        wrData <= {shiftIn[6:0], dinLvl};
                        wrStb <= 1'b1;
                    end
                end
                // Read data leaves on falling edges
                if (clkFall && isRead && bitCnt >= 5'h10 && bitCnt <= 5'h17) begin
                    sdioOut <= txShift[7];
                    txShift <= {txShift[6:0], 1'b0};
                    sdioOe <= 1'b1;
                end
            end
        end
    end
endmodule // scd_spi_port

// ===== scd_clock_chk.sv
`timescale 1ns/1ns
module scd_clock_chk (
    input wire sys_clk,
    input wire rst,
    input wire [1:0] sampleTick,
    input wire [7:0] fineStepA,
    input wire [7:0] fineStepB,
    input wire [7:0] superStepA,
    input wire [7:0] superStepB,
    input wire datapathReset,
    input wire duty_stabiliser_stage_one,
    input wire duty_stabiliser_stage_two,
    input wire powerDown,
    input wire standby,
    input wire linkEnable,
    input wire sampleZero,
    input wire sendKChars
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Datapath reset pulse, divided strobe, step limits, stabiliser, link states
    chk_dp_rst_len: assert property ($rose(datapathReset) |-> datapathReset[*4] ##1 !datapathReset)
        else $error("datapath reset pulse length wrong");
    chk_tick_gap: assert property (!powerDown && !sampleTick[0] |-> ##[1:8] sampleTick[0])
        else $error("sample strobe missing");
    chk_fine_max: assert property (fineStepA <= 8'hBF && fineStepB <= 8'hBF)
        else $error("fine step above range");
    chk_super_max: assert property (superStepA <= 8'h80 && superStepB <= 8'h80)
        else $error("superfine step above range");
    chk_duty_init: assert property ($fell(rst) |-> duty_stabiliser_stage_one && duty_stabiliser_stage_two)
        else $error("stabiliser off after reset");
    chk_pd_link: assert property (powerDown |-> !linkEnable)
        else $error("link running in power-down");
    chk_standby_out: assert property (standby && !powerDown |-> linkEnable && (sampleZero ^ sendKChars))
        else $error("standby output wrong");
    chk_link_up: assert property ((!powerDown)[*3] |-> linkEnable)
        else $error("link dropped");
endmodule // scd_clock_chk

bind scd_clock_ctrl scd_clock_chk chk_u (.sys_clk, .rst, .sampleTick, .fineStepA, .fineStepB,
    .superStepA, .superStepB, .datapathReset, .duty_stabiliser_stage_one,
    .duty_stabiliser_stage_two, .powerDown, .standby, .linkEnable, .sampleZero, .sendKChars);

// ===== scd_host_model.sv
`timescale 1ns/1ns
module scd_host_model (
    input wire sys_clk,
    input wire sdioOe,
    input wire sdioOut,
    output logic spiClk,
    output logic spiCsN,
    output wire sdioIn
);
    logic hostBit;
    // Shared data pin: device drives while its enable is high
    assign sdioIn = sdioOe ? sdioOut : hostBit;
    initial begin
        spiClk = 1'b0;
        spiCsN = 1'b1;
        hostBit = 1'b0;
    end
    // One transaction: 16-bit instruction then 8 data bits, MSB first, slow clock
    task xfer(input logic rd, input logic [14:0] a, input logic [7:0] wd, output logic [7:0] rv);
        logic [23:0] frame;
        integer i;
        begin
            frame = {rd, a, wd};
            rv = 8'h00;
            spiCsN = 1'b0;
            for (i = 23; i >= 0; i = i - 1) begin
                // Released line wanders instead of holding the last bit
                hostBit = (rd && i < 8) ? ~hostBit : frame[i];
                repeat (6) @(negedge sys_clk);
                if (rd && i < 8) rv[i] = sdioIn;
                spiClk = 1'b1;
                repeat (6) @(negedge sys_clk);
                spiClk = 1'b0;
            end
            repeat (6) @(negedge sys_clk);
            spiCsN = 1'b1;
            repeat (8) @(negedge sys_clk);
        end
    endtask
endmodule // scd_host_model

// ===== tb_top.sv
`timescale 1ns/1ns
`include "scd_regs.vh"
`define TB_CMP(a, e) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, a, e); end end
module tb_top;
    logic sys_clk = 1'b0;
    logic rst, refPin, pwrPin, watchLink;
    wire spiClk, spiCsN, sdioIn, sdioOut, sdioOe, datapathReset, powerDown, standby;
    wire linkEnable, sampleZero, sendKChars, diodeSmallExport, diodeLargeExport;
    wire duty_stabiliser_stage_one, duty_stabiliser_stage_two;
    wire refExternalEn, common_mode_voltage_export;
    wire [1:0] sampleTick;
    wire [7:0] fineStepA, fineStepB, superStepA, superStepB;
    int n_mismatch, n_checks, tickCnt, dpCnt, linkDrop, t0, c, seedVal;
    int cycN, lastTick, lastTick1, ph[2];
    logic [7:0] fv, sv;
    always #4 sys_clk = ~sys_clk;
    scd_clock_ctrl dut_u (.sys_clk, .rst, .spiClk, .spiCsN, .sdioIn,
        .system_reference_input(refPin), .power_control_pin(pwrPin), .sdioOut, .sdioOe,
        .sampleTick, .fineStepA, .fineStepB, .superStepA, .superStepB, .datapathReset,
        .duty_stabiliser_stage_one, .duty_stabiliser_stage_two, .powerDown, .standby,
        .linkEnable, .sampleZero, .sendKChars, .diodeSmallExport, .diodeLargeExport,
        .refExternalEn, .common_mode_voltage_export);
    scd_host_model host_u (.sys_clk, .sdioOe, .sdioOut, .spiClk, .spiCsN, .sdioIn);
    // Counts strobes, datapath reset cycles and link drops
    always @(posedge sys_clk) begin
        cycN++;
        if (sampleTick[0] === 1'b1) begin
            tickCnt++;
            lastTick = cycN;
        end
        if (sampleTick[1] === 1'b1) lastTick1 = cycN;
        if (datapathReset === 1'b1) dpCnt++;
        if (watchLink && linkEnable !== 1'b1) linkDrop++;
    end
    function automatic [7:0] expFine(input [2:0] s, input [7:0] v);
        if (s == 3'h0) expFine = 8'h00;
        else if (s == 3'h1) expFine = {4'h0, v[3:0]};
        else expFine = (v > 8'hBF) ? 8'hBF : v;
    endfunction
    function automatic [7:0] expSuper(input [2:0] s, input [7:0] v);
        expSuper = (s == 3'h2 || s == 3'h6) ? ((v > 8'h80) ? 8'h80 : v) : 8'h00;
    endfunction
    task wr(input logic [14:0] a, input logic [7:0] d);
        logic [7:0] x;
        begin host_u.xfer(1'b0, a, d, x); end
    endtask
    task rdChk(input logic [14:0] a, input logic [7:0] e);
        logic [7:0] x;
        begin host_u.xfer(1'b1, a, 8'h00, x); `TB_CMP(x, e) end
    endtask
    task print_verdict;
        begin
            $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
            if (n_mismatch == 0 && n_checks > 0) $display("ALL TESTS PASSED");
            else $display("TESTS FAILED");
            $finish;
        end
    endtask
    // Run limit
    initial begin
        #800000;
        n_mismatch++;
        print_verdict;
    end
    // Main sequence
    initial begin
        rst = 1'b1; refPin = 1'b0; pwrPin = 1'b0; watchLink = 1'b0;
        seedVal = $urandom(83);
        repeat (2) @(negedge sys_clk);
        rst = 1'b0;
        repeat (6) @(negedge sys_clk);
        `TB_CMP(duty_stabiliser_stage_one & duty_stabiliser_stage_two, 1'b1);
        rdChk(`SCD_ADDR_DUTY_A, 8'h01);
        rdChk(`SCD_ADDR_DUTY_B, 8'h01);
        rdChk(`SCD_ADDR_CHAN_SEL, 8'h03);
        rdChk(`SCD_ADDR_FINE, 8'h00);
        wr(15'h0123, 8'h5A);
        rdChk(15'h0123, 8'h00);
        watchLink = 1'b1;
        for (c = 0; c < 3; c++) begin
            fv = (c == 2) ? 8'h02 : $urandom;
            wr(`SCD_ADDR_HALF_DELAY, fv);
            rdChk(`SCD_ADDR_HALF_DELAY, fv);
        end
        // both channels get the same delay settings
        for (c = 0; c < 8; c++) begin
            fv = (c == 7) ? 8'hFF : (c == 3) ? 8'hBF : $urandom;
            sv = (c == 6) ? 8'h81 : $urandom;
            wr(`SCD_ADDR_DELAY_SEL, 8'h00);
            wr(`SCD_ADDR_FINE, fv);
            wr(`SCD_ADDR_SUPERFINE, sv);
            t0 = dpCnt;
            wr(`SCD_ADDR_DELAY_SEL, c[7:0]);
            `TB_CMP(dpCnt - t0, (c != 0) ? 4 : 0);
            `TB_CMP(fineStepA, expFine(c[2:0], fv));
            `TB_CMP(fineStepB, expFine(c[2:0], fv));
            `TB_CMP(superStepA, expSuper(c[2:0], sv));
            `TB_CMP(superStepB, expSuper(c[2:0], sv));
        end
        wr(`SCD_ADDR_CHAN_SEL, 8'h01);
        wr(`SCD_ADDR_FINE, 8'h10);
        `TB_CMP({fineStepA, fineStepB}, 16'h10BF);
        wr(`SCD_ADDR_CHAN_SEL, 8'h03);
        `TB_CMP(linkDrop, 0);
        watchLink = 1'b0;
        // Ratio chosen before counting strobes
        for (c = 0; c < 3; c++) begin
            wr(`SCD_ADDR_DIV_RATIO, (c == 2) ? 8'h03 : c[7:0]);
            t0 = tickCnt;
            repeat (32) @(negedge sys_clk);
            `TB_CMP(tickCnt - t0, 32 >> c);
        end
        // Load state 0 then 2: strobe phase must move by two cycles
        for (c = 0; c < 2; c++) begin
            wr(`SCD_ADDR_REF_SYNC, (c == 1) ? 8'h05 : 8'h01);
            refPin = 1'b1;
            ph[c] = cycN;
            repeat (4) @(negedge sys_clk);
            refPin = 1'b0;
            t0 = tickCnt;
            repeat (32) @(negedge sys_clk);
            `TB_CMP(tickCnt - t0, 8);
            ph[c] = (lastTick - ph[c]) & 3;
        end
        `TB_CMP((ph[0] - ph[1]) & 3, 2);
        `TB_CMP((lastTick1 - lastTick) & 3, 1);
        rdChk(`SCD_ADDR_REF_SYNC, 8'h05);
        pwrPin = 1'b1;
        repeat (8) @(negedge sys_clk);
        `TB_CMP({powerDown, linkEnable}, 2'h2);
        pwrPin = 1'b0;
        wr(`SCD_ADDR_PWR_A, 8'h01);
        `TB_CMP({powerDown, linkEnable}, 2'h2);
        wr(`SCD_ADDR_PWR_A, 8'h00);
        wr(`SCD_ADDR_PWR_B, 8'h01);
        pwrPin = 1'b1;
        repeat (8) @(negedge sys_clk);
        `TB_CMP({standby, linkEnable, sampleZero, sendKChars}, 4'hE);
        wr(`SCD_ADDR_STANDBY_OUT, 8'h80);
        `TB_CMP({standby, linkEnable, sampleZero, sendKChars}, 4'hD);
        pwrPin = 1'b0;
        wr(`SCD_ADDR_CM_EXPORT, 8'h40);
        wr(`SCD_ADDR_REF_EXPORT, 8'h01);
        `TB_CMP({refExternalEn, common_mode_voltage_export}, 2'h3);
        // Both channels selected and other exports off before diode export
        wr(`SCD_ADDR_CHAN_SEL, 8'h03);
        wr(`SCD_ADDR_CM_EXPORT, 8'h00);
        wr(`SCD_ADDR_REF_EXPORT, 8'h00);
        `TB_CMP({refExternalEn, common_mode_voltage_export}, 2'h0);
        for (c = 1; c < 4; c++) begin
            wr(`SCD_ADDR_DIODE_EXPORT, c[7:0]);
            `TB_CMP({diodeSmallExport, diodeLargeExport}, {c == 1, c == 2});
        end
        print_verdict;
    end
endmodule // tb_top
